// ==== src/pss_params.svh ====
// Constants for the PHY status summary register bank.
// Assumes a 32-bit AXI4-Lite slave whose word index is address bits 7:2.
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// Register word indices; byte address is four times the index.
`define PSS_IDX_BASIC    6'h01
`define PSS_IDX_EXPAN    6'h06
`define PSS_IDX_SUM      6'h10
`define PSS_IDX_INTST    6'h12
`define PSS_IDX_FCC      6'h14
`define PSS_IDX_CTRL     6'h16
`define PSS_IDX_IRQST    6'h20
`define PSS_IDX_IRQMSK   6'h21

// Summary field positions.
`define PSS_SUM_FCL      11
`define PSS_SUM_SD       10
`define PSS_SUM_LOCK     9
`define PSS_SUM_PAGE     8
`define PSS_SUM_INTP     7
`define PSS_SUM_RFAULT   6
`define PSS_SUM_JAB      5
`define PSS_SUM_ANC      4
`define PSS_SUM_LOOP     3
`define PSS_SUM_DUPLEX   2
`define PSS_SUM_SPEED10  1
`define PSS_SUM_LINK     0

// Basic status, expansion and control field positions.
`define PSS_BAS_JAB      1
`define PSS_BAS_LINK     2
`define PSS_BAS_RFAULT   4
`define PSS_BAS_ANC      5
`define PSS_EXP_PAGE     1
`define PSS_CTRL_QUAL    8

// Reset values and limits.
`define PSS_CTRL_RST     16'h0000
`define PSS_MASK_RST     4'h0
`define PSS_FCC_MAX      8'hff
`define PSS_RESP_OKAY    2'h0
`define PSS_RESP_DECERR  2'h3

`endif

// ==== src/pss_pkg.sv ====
// Types shared by the PHY status summary register bank.
// Assumes pss_params.svh supplies the numeric constants.
package pss_pkg;

    typedef enum logic [3:0] {
        PSS_R_NONE,
        PSS_R_BASIC,
        PSS_R_EXPAN,
        PSS_R_SUM,
        PSS_R_INTST,
        PSS_R_FCC,
        PSS_R_CTRL,
        PSS_R_IRQST,
        PSS_R_IRQMSK
    } pss_reg_type;

endpackage

// ==== src/pss_latch_low.sv ====
// Latched-low status flag.
// Assumes rd_clr pulses for one cycle when the flag's value is returned to software.
module pss_latch_low (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Live condition and read strobe
    input  wire logic live,
    input  wire logic rd_clr,
    // Latched value
    output logic      q
);

    logic next_q;

    // Once low, the flag only follows the live value again after a read has shown the zero.
    always_comb begin
        if (rd_clr) begin
            next_q = live;
        end else begin
            next_q = q & live;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

endmodule

// ==== src/pss_top.sv ====
// PHY status summary register bank with its companion clear-on-read registers.
// Assumes AXI4-Lite from one master and PHY status inputs synchronous to aclk.
//
// Operation
// - False carrier latch sets on any event, clears on counter register read.
// - Bit 10 is qualified signal detect, optionally ANDed with lock, latched low.
// - Bit 9 is descrambler lock, latched low, resets to zero.
// - Bit 8 mirrors page received; cleared only by expansion register read.
// - Bit 7 shows interrupt pending; interrupt status read clears it.
// - Bit 6 sets on partner remote fault; cleared by basic status read.
// - Jabber field duplicates basic status jabber, not cleared by summary read.
// - Bit 4 reads one once auto-negotiation has completed.
// - Bit 3 reads one while loopback is enabled.
// - Bit 2 reports resolved duplex, one for full duplex.
// - Bit 1 reports resolved speed, one for 10 Mb/s.
// - Bit 0 duplicates link status, not cleared by summary read.
// - Summary register sits at management address 10h as one word.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`include "pss_params.svh"

module pss_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // PHY event pulses
    input  wire logic        false_carrier_event,
    input  wire logic        page_received_event,
    input  wire logic        internal_int_event,
    input  wire logic        remote_fault_event,
    input  wire logic        jabber_detect,
    input  wire logic [7:0]  int_source_flags,
    // PHY live status levels
    input  wire logic        raw_signal_detect,
    input  wire logic        descrambler_lock,
    input  wire logic        autoneg_complete,
    input  wire logic        loopback_enable,
    input  wire logic        duplex_full,
    input  wire logic        speed_10,
    input  wire logic        link_up,
    // Interrupt
    output logic             irq
);

    // Write channel and writable registers.
    logic                     aw_held;
    logic                     w_held;
    logic [7:0]               aw_addr_q;
    logic [15:0]              w_data_q;
    logic [1:0]               w_strb_q;
    logic [15:0]              ctrl;
    logic [3:0]               irq_mask;
    logic                     next_aw_held;
    logic                     next_w_held;
    logic [7:0]               next_aw_addr_q;
    logic [15:0]              next_w_data_q;
    logic [1:0]               next_w_strb_q;
    logic [15:0]              next_ctrl;
    logic [3:0]               next_irq_mask;
    logic                     next_awready;
    logic                     next_wready;
    logic                     next_bvalid;
    logic [1:0]               next_bresp;

    // Read channel.
    pss_pkg::pss_reg_type     rd_reg;
    logic                     next_arready;
    logic                     next_rvalid;
    logic [31:0]              next_rdata;
    logic [1:0]               next_rresp;

    // Status state.
    logic                     fc_latch;
    logic [7:0]               fc_count;
    logic                     page_rcv;
    logic                     int_pend;
    logic                     rfault;
    logic                     jabber;
    logic [3:0]               irq_status;
    logic                     next_fc_latch;
    logic [7:0]               next_fc_count;
    logic                     next_page_rcv;
    logic                     next_int_pend;
    logic                     next_rfault;
    logic                     next_jabber;
    logic [3:0]               next_irq_status;
    logic                     next_irq;
    logic                     qual_sd;
    logic                     sd_ll;
    logic                     lock_ll;
    logic                     rd_sum;
    logic [15:0]              summary;

    function automatic pss_pkg::pss_reg_type pss_decode(input logic [7:0] addr);
        pss_pkg::pss_reg_type r;
        r = pss_pkg::PSS_R_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[7:2])
                `PSS_IDX_BASIC:  r = pss_pkg::PSS_R_BASIC;
                `PSS_IDX_EXPAN:  r = pss_pkg::PSS_R_EXPAN;
                `PSS_IDX_SUM:    r = pss_pkg::PSS_R_SUM;
                `PSS_IDX_INTST:  r = pss_pkg::PSS_R_INTST;
                `PSS_IDX_FCC:    r = pss_pkg::PSS_R_FCC;
                `PSS_IDX_CTRL:   r = pss_pkg::PSS_R_CTRL;
                `PSS_IDX_IRQST:  r = pss_pkg::PSS_R_IRQST;
                `PSS_IDX_IRQMSK: r = pss_pkg::PSS_R_IRQMSK;
                default:         r = pss_pkg::PSS_R_NONE;
            endcase
        end
        return r;
    endfunction

    function automatic logic [15:0] pss_apply_strb(input logic [15:0] old,
                                                   input logic [15:0] data,
                                                   input logic [1:0]  strb);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v;
    endfunction

    // Address and data may arrive in either order; each is parked until its partner comes.
    always_comb begin
        logic                 aw_fire;
        logic                 w_fire;
        logic [7:0]           wa;
        logic [15:0]          wd;
        logic [1:0]           ws;
        logic [15:0]          mask_word;
        pss_pkg::pss_reg_type wr_reg;
        aw_fire        = s_axi_awvalid & s_axi_awready;
        w_fire         = s_axi_wvalid & s_axi_wready;
        wa             = aw_fire ? s_axi_awaddr : aw_addr_q;
        wd             = w_fire ? s_axi_wdata[15:0] : w_data_q;
        ws             = w_fire ? s_axi_wstrb[1:0] : w_strb_q;
        wr_reg         = pss_decode(wa);
        mask_word      = 16'h0000;
        next_aw_held   = aw_held | aw_fire;
        next_w_held    = w_held | w_fire;
        next_aw_addr_q = wa;
        next_w_data_q  = wd;
        next_w_strb_q  = ws;
        next_ctrl      = ctrl;
        next_irq_mask  = irq_mask;
        next_bresp     = s_axi_bresp;
        next_bvalid    = s_axi_bvalid & ~s_axi_bready;
        if (next_aw_held && next_w_held) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_reg == pss_pkg::PSS_R_NONE) ? `PSS_RESP_DECERR : `PSS_RESP_OKAY;
            if (wr_reg == pss_pkg::PSS_R_CTRL) begin
                next_ctrl = pss_apply_strb(ctrl, wd, ws);
            end
            if (wr_reg == pss_pkg::PSS_R_IRQMSK) begin
                mask_word     = pss_apply_strb({12'h000, irq_mask}, wd, ws);
                next_irq_mask = mask_word[3:0];
            end
        end
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready  = ~next_w_held & ~next_bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 16'h0000;
            w_strb_q      <= 2'h0;
            ctrl          <= `PSS_CTRL_RST;
            irq_mask      <= `PSS_MASK_RST;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PSS_RESP_OKAY;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr_q     <= next_aw_addr_q;
            w_data_q      <= next_w_data_q;
            w_strb_q      <= next_w_strb_q;
            ctrl          <= next_ctrl;
            irq_mask      <= next_irq_mask;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
        end
    end

    always_comb begin
        summary                   = 16'h0000;
        summary[`PSS_SUM_FCL]     = fc_latch;
        summary[`PSS_SUM_SD]      = sd_ll;
        summary[`PSS_SUM_LOCK]    = lock_ll;
        summary[`PSS_SUM_PAGE]    = page_rcv;
        summary[`PSS_SUM_INTP]    = int_pend;
        summary[`PSS_SUM_RFAULT]  = rfault;
        summary[`PSS_SUM_JAB]     = jabber;
        summary[`PSS_SUM_ANC]     = autoneg_complete;
        summary[`PSS_SUM_LOOP]    = loopback_enable;
        summary[`PSS_SUM_DUPLEX]  = duplex_full;
        summary[`PSS_SUM_SPEED10] = speed_10;
        summary[`PSS_SUM_LINK]    = link_up;
    end

    // The read data is captured at the address handshake, so clear-on-read sees the same cycle.
    always_comb begin
        logic ar_fire;
        ar_fire      = s_axi_arvalid & s_axi_arready;
        rd_reg       = ar_fire ? pss_decode(s_axi_araddr) : pss_pkg::PSS_R_NONE;
        next_rvalid  = s_axi_rvalid & ~s_axi_rready;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (ar_fire) begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h0000_0000;
            next_rresp  = `PSS_RESP_OKAY;
            unique case (rd_reg)
                pss_pkg::PSS_R_NONE: begin
                    next_rresp = `PSS_RESP_DECERR;
                end
                pss_pkg::PSS_R_BASIC: begin
                    next_rdata[`PSS_BAS_JAB]    = jabber;
                    next_rdata[`PSS_BAS_LINK]   = link_up;
                    next_rdata[`PSS_BAS_RFAULT] = rfault;
                    next_rdata[`PSS_BAS_ANC]    = autoneg_complete;
                end
                pss_pkg::PSS_R_EXPAN: begin
                    next_rdata[`PSS_EXP_PAGE] = page_rcv;
                end
                pss_pkg::PSS_R_SUM: begin
                    next_rdata[15:0] = summary;
                end
                pss_pkg::PSS_R_INTST: begin
                    next_rdata[15:8] = int_source_flags;
                    next_rdata[0]    = int_pend;
                end
                pss_pkg::PSS_R_FCC: begin
                    next_rdata[7:0] = fc_count;
                end
                pss_pkg::PSS_R_CTRL: begin
                    next_rdata[15:0] = ctrl;
                end
                pss_pkg::PSS_R_IRQST: begin
                    next_rdata[3:0] = irq_status;
                end
                pss_pkg::PSS_R_IRQMSK: begin
                    next_rdata[3:0] = irq_mask;
                end
            endcase
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PSS_RESP_OKAY;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // Sticky flags: an event in the cycle of the clearing read wins, so none is lost.
    always_comb begin
        logic [3:0] events;
        events = {internal_int_event, remote_fault_event, page_received_event, false_carrier_event};
        rd_sum = (rd_reg == pss_pkg::PSS_R_SUM);
        qual_sd = raw_signal_detect & (descrambler_lock | ~ctrl[`PSS_CTRL_QUAL]);
        next_fc_latch = (fc_latch & (rd_reg != pss_pkg::PSS_R_FCC)) | false_carrier_event;
        if (rd_reg == pss_pkg::PSS_R_FCC) begin
            next_fc_count = {7'h00, false_carrier_event};
        end else if (false_carrier_event && (fc_count != `PSS_FCC_MAX)) begin
            next_fc_count = fc_count + 8'h01;
        end else begin
            next_fc_count = fc_count;
        end
        next_page_rcv = (page_rcv & (rd_reg != pss_pkg::PSS_R_EXPAN)) | page_received_event;
        next_int_pend = (int_pend & (rd_reg != pss_pkg::PSS_R_INTST)) | internal_int_event;
        next_rfault   = (rfault & (rd_reg != pss_pkg::PSS_R_BASIC)) | remote_fault_event;
        next_jabber   = (jabber & (rd_reg != pss_pkg::PSS_R_BASIC)) | jabber_detect;
        next_irq_status = (irq_status & ~{4{rd_reg == pss_pkg::PSS_R_IRQST}}) | events;
        next_irq        = |(next_irq_status & irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fc_latch   <= 1'b0;
            fc_count   <= 8'h00;
            page_rcv   <= 1'b0;
            int_pend   <= 1'b0;
            rfault     <= 1'b0;
            jabber     <= 1'b0;
            irq_status <= 4'h0;
            irq        <= 1'b0;
        end else begin
            fc_latch   <= next_fc_latch;
            fc_count   <= next_fc_count;
            page_rcv   <= next_page_rcv;
            int_pend   <= next_int_pend;
            rfault     <= next_rfault;
            jabber     <= next_jabber;
            irq_status <= next_irq_status;
            irq        <= next_irq;
        end
    end

    pss_latch_low u_sd_latch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (qual_sd),
        .rd_clr  (rd_sum),
        .q       (sd_ll)
    );

    pss_latch_low u_lock_latch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .live    (descrambler_lock),
        .rd_clr  (rd_sum),
        .q       (lock_ll)
    );

endmodule

// ==== verif/pss_top_monitor.sv ====
// Port-level checks for the PHY status summary register bank.
// Assumes one aclk domain with a synchronous active-low reset.
`include "pss_params.svh"

module pss_top_monitor (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // PHY status
    input wire logic        false_carrier_event,
    input wire logic        page_received_event,
    input wire logic        internal_int_event,
    input wire logic        remote_fault_event,
    input wire logic        raw_signal_detect,
    input wire logic        descrambler_lock,
    input wire logic        autoneg_complete,
    input wire logic        loopback_enable,
    input wire logic        duplex_full,
    input wire logic        speed_10,
    input wire logic        link_up
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [4:0] live;
    logic       sd_dropped;
    logic       lock_dropped;
    logic       next_sd_dropped;
    logic       next_lock_dropped;
    logic       sum_take;

    assign live = {autoneg_complete, loopback_enable, duplex_full, speed_10, link_up};
    assign sum_take = s_axi_arvalid && s_axi_arready && s_axi_araddr == {`PSS_IDX_SUM, 2'b00};

    // A summary read reloads the latch; drops count from the last one.
    always_comb begin
        next_sd_dropped = sum_take ? !raw_signal_detect : (sd_dropped || !raw_signal_detect);
        next_lock_dropped = sum_take ? !descrambler_lock : (lock_dropped || !descrambler_lock);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sd_dropped <= 1'b1;
            lock_dropped <= 1'b1;
        end else begin
            sd_dropped <= next_sd_dropped;
            lock_dropped <= next_lock_dropped;
        end
    end

    sequence sum_read;
        sum_take;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp moved before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata moved before taken");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    wr_answer_a: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write answer late");
    sum_upper_a: assert property (sum_read |=> s_axi_rdata[31:12] == 20'h0 && s_axi_rresp == 2'h0)
        else $error("summary upper bits or response wrong");
    live_bits_a: assert property (sum_read |=> s_axi_rdata[4:0] == $past(live))
        else $error("live bits differ");
    fcl_set_a: assert property (false_carrier_event ##[1:2] sum_read |=> s_axi_rdata[`PSS_SUM_FCL])
        else $error("false carrier latch not set");
    page_set_a: assert property (page_received_event ##[1:2] sum_read |=> s_axi_rdata[`PSS_SUM_PAGE])
        else $error("page received not set");
    int_set_a: assert property (internal_int_event ##[1:2] sum_read |=> s_axi_rdata[`PSS_SUM_INTP])
        else $error("interrupt pending not set");
    fault_set_a: assert property (remote_fault_event ##[1:2] sum_read |=> s_axi_rdata[`PSS_SUM_RFAULT])
        else $error("remote fault not set");
    sd_low_a: assert property (sum_read ##0 sd_dropped |=> !s_axi_rdata[`PSS_SUM_SD])
        else $error("signal detect not low");
    lock_low_a: assert property (sum_read ##0 lock_dropped |=> !s_axi_rdata[`PSS_SUM_LOCK])
        else $error("lock not low");
endmodule

bind pss_top pss_top_monitor pss_top_monitor_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .false_carrier_event, .page_received_event,
    .internal_int_event, .remote_fault_event, .raw_signal_detect, .descrambler_lock,
    .autoneg_complete, .loopback_enable, .duplex_full, .speed_10, .link_up
);

// ==== verif/pss_top_test.sv ====
// Self-checking bench for the PHY status summary register bank.
// Drives the ports itself; a cycle ceiling ends a hung run.
`include "pss_params.svh"

`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module pss_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam A_BAS = {`PSS_IDX_BASIC, 2'b00};
    localparam A_EXP = {`PSS_IDX_EXPAN, 2'b00};
    localparam A_SUM = {`PSS_IDX_SUM, 2'b00};
    localparam A_INT = {`PSS_IDX_INTST, 2'b00};
    localparam A_FCC = {`PSS_IDX_FCC, 2'b00};
    localparam A_CTL = {`PSS_IDX_CTRL, 2'b00};
    localparam A_IST = {`PSS_IDX_IRQST, 2'b00};
    localparam A_MSK = {`PSS_IDX_IRQMSK, 2'b00};

    logic        aclk, aresetn, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, int_source_flags;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        false_carrier_event, page_received_event, internal_int_event, remote_fault_event, jabber_detect;
    logic        raw_signal_detect, descrambler_lock, autoneg_complete, loopback_enable, duplex_full, speed_10, link_up;
    int          bad_count, n_compared, cycles;

    pss_top pss_top_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .false_carrier_event, .page_received_event, .internal_int_event, .remote_fault_event, .jabber_detect,
        .int_source_flags, .raw_signal_detect, .descrambler_lock, .autoneg_complete, .loopback_enable,
        .duplex_full, .speed_10, .link_up, .irq
    );

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Address and data rise together; each drops at its own handshake.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        `CHK($sformatf("register %h", a), e, d & m)
    endtask

    // Order is false carrier, page, internal interrupt, remote fault, jabber, signal detect, lock.
    task automatic pulse(input logic [6:0] ev);
        @(posedge aclk);
        {false_carrier_event, page_received_event, internal_int_event, remote_fault_event, jabber_detect,
         raw_signal_detect, descrambler_lock} <= ev;
        @(posedge aclk);
        {false_carrier_event, page_received_event, internal_int_event, remote_fault_event, jabber_detect,
         raw_signal_detect, descrambler_lock} <= 7'h03;
    endtask

    task automatic t_reset();
        chk_rd(A_SUM, 32'hffffffff, 32'h00000000);
        $display("t_reset done");
    endtask

    task automatic t_live();
        logic [4:0] pat;
        for (int i = 0; i < 2; i++) begin
            pat = i ? 5'h0a : 5'h15;
            {autoneg_complete, loopback_enable, duplex_full, speed_10, link_up} <= pat;
            chk_rd(A_SUM, 32'hfffff01f, {27'h0, pat});
        end
        $display("t_live done");
    endtask

    task automatic t_events();
        pulse(7'h7f);
        chk_rd(A_SUM, 32'h9e0, 32'h9e0);
        chk_rd(A_SUM, 32'h9e0, 32'h9e0);
        chk_rd(A_FCC, 32'h0ff, 32'h001);
        chk_rd(A_SUM, 32'h9e0, 32'h1e0);
        chk_rd(A_EXP, 32'h002, 32'h002);
        chk_rd(A_SUM, 32'h1e0, 32'h0e0);
        chk_rd(A_INT, 32'hff01, 32'ha501);
        chk_rd(A_SUM, 32'h0e0, 32'h060);
        chk_rd(A_BAS, 32'h012, 32'h012);
        chk_rd(A_SUM, 32'h060, 32'h000);
        $display("t_events done");
    endtask

    task automatic t_latch();
        chk_rd(A_SUM, 32'h600, 32'h600);
        pulse(7'h02);
        chk_rd(A_SUM, 32'h600, 32'h400);
        chk_rd(A_SUM, 32'h600, 32'h600);
        wr(A_CTL, 32'h100);
        chk_rd(A_CTL, 32'hffff, 32'h0100);
        pulse(7'h02);
        chk_rd(A_SUM, 32'h600, 32'h000);
        chk_rd(A_SUM, 32'h600, 32'h600);
        pulse(7'h01);
        chk_rd(A_SUM, 32'h600, 32'h200);
        wr(A_CTL, 32'h0);
        $display("t_latch done");
    endtask

    task automatic t_irq();
        chk_rd(A_IST, 32'hf, 32'hf);
        `CHK("irq masked", 1'b0, irq)
        wr(A_MSK, 32'h1);
        `CHK("mask bresp", `PSS_RESP_OKAY, resp)
        chk_rd(A_MSK, 32'hf, 32'h1);
        pulse(7'h23);
        repeat (2) @(negedge aclk);
        `CHK("irq masked event", 1'b0, irq)
        pulse(7'h43);
        repeat (2) @(negedge aclk);
        `CHK("irq raised", 1'b1, irq)
        chk_rd(A_IST, 32'hf, 32'h3);
        repeat (2) @(negedge aclk);
        `CHK("irq cleared", 1'b0, irq)
        rd(8'h30);
        `CHK("bad rresp", `PSS_RESP_DECERR, resp)
        `CHK("bad rdata", 32'h0, d)
        wr(8'h30, 32'h1);
        `CHK("bad bresp", `PSS_RESP_DECERR, resp)
        $display("t_irq done");
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {false_carrier_event, page_received_event, internal_int_event, remote_fault_event, jabber_detect} = '0;
        {autoneg_complete, loopback_enable, duplex_full, speed_10, link_up} = '0;
        {raw_signal_detect, descrambler_lock} = 2'h3;
        s_axi_wstrb = 4'h3;
        int_source_flags = 8'ha5;
        {bad_count, n_compared, cycles} = '0;
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_live();
        t_events();
        t_latch();
        t_irq();
        stop_test();
    end
endmodule
